// ==== verilog/expander_ctl_pkg.sv ====
// Constants, register map and state types of the expander control block.
// Assumes a 250 MHz clock and a byte-level I2C slave front end outside.
package expander_ctl_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] REG_FEATURE_ENABLE = 8'h2D;
	localparam logic [7:0] REG_FAMILY_STATUS = 8'h2E;
	localparam logic [7:0] REG_WATCHDOG = 8'h2F;
	localparam logic [7:0] REG_COMMAND = 8'h30;

	// ********************************
	// Feature enable fields and unlock key
	// ********************************
	localparam int ENA_WP_SEL_BIT = 0;
	localparam int ENA_EE_OP_BIT = 1;
	localparam int ENA_RO_BIT = 2;
	localparam logic [7:0] ENA_RESET = 8'h00;
	localparam logic [7:0] ENA_MASK = 8'h07;
	localparam logic [7:0] KEY_BYTE0 = 8'h43;
	localparam logic [7:0] KEY_BYTE1 = 8'h4D;
	localparam logic [7:0] KEY_BYTE2 = 8'h53;
	localparam logic [1:0] KEY_LEN = 2'h3;

	// ********************************
	// Status and watchdog
	// ********************************
	localparam logic [3:0] STATUS_FACTORY = 4'hF;
	localparam logic [3:0] STATUS_USER = 4'h0;
	localparam logic [7:0] WD_RESET = 8'h00;
	localparam longint SECOND_NS = 1000000000;
	localparam longint CLK_NS = 4;
	localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_NS);

	// ********************************
	// Commands
	// ********************************
	localparam logic [7:0] CMD_STORE_CFG = 8'h01;
	localparam logic [7:0] CMD_FACTORY = 8'h02;
	localparam logic [7:0] CMD_WRITE_DFLT = 8'h03;
	localparam logic [7:0] CMD_READ_DFLT = 8'h04;
	localparam logic [7:0] CMD_WRITE_CFG = 8'h05;
	localparam logic [7:0] CMD_READ_CFG = 8'h06;
	localparam logic [7:0] CMD_RECONFIG = 8'h07;

	// ********************************
	// Configuration block layout
	// ********************************
	localparam logic [7:0] OFS_OUT = 8'h00;
	localparam logic [7:0] OFS_IMASK = 8'h08;
	localparam logic [7:0] OFS_PWMSEL = 8'h10;
	localparam logic [7:0] OFS_INV = 8'h18;
	localparam logic [7:0] OFS_DIR = 8'h20;
	localparam logic [7:0] OFS_DRIVE = 8'h28;
	localparam logic [7:0] DRIVE_PER_PORT = 8'h07;
	localparam logic [7:0] OFS_PWM = 8'h60;
	localparam logic [7:0] PWM_PER_CH = 8'h03;
	localparam logic [7:0] PWM_PERIOD_SLOT = 8'h01;
	localparam logic [7:0] OFS_DIVIDER = 8'h90;
	localparam logic [7:0] OFS_ENABLE = 8'h91;
	localparam logic [7:0] OFS_CRC = 8'h92;
	localparam logic [7:0] BLK_LEN = 8'h92;
	localparam logic [7:0] FACT_OUT = 8'hFF;
	localparam logic [7:0] FACT_IMASK = 8'hFF;
	localparam logic [7:0] FACT_PULLUP = 8'hFF;
	localparam logic [7:0] FACT_PERIOD = 8'hFF;
	localparam logic [7:0] FACT_DIVIDER = 8'hFF;

	// ********************************
	// State types
	// ********************************
	typedef enum {ENG_IDLE, ENG_NV_READ, ENG_CHECK, ENG_APPLY, ENG_FACT_CFG, ENG_SNAP, ENG_NV_WRITE} eng_e;
	typedef enum {STR_NONE, STR_WR_NV, STR_WR_CFG, STR_RD} stream_e;
	typedef enum {SRC_CFG, SRC_FACT, SRC_STG} src_e;
	typedef enum {THEN_BOOT, THEN_STREAM} then_e;

endpackage

// ==== verilog/expander_config_command_control.sv ====
// Control section of the IO expander: keyed enable register, status, watchdog and block commands.
// Assumes an I2C slave front end delivering bytes and a one-cycle-latency default store.
//
// Function
// - Enable bits: 2 read-only EEPROM, 1 EEPROM operation, 0 write-protect pin select.
// - Reset clears all three enable bits.
// - A register write changes the enable register only after address 2Dh then keys 43h, 4Dh, 53h.
// - Enable register reads back without any key.
// - Burst writes crossing the enable register are discarded, pointer moves to 2Eh.
// - Status register is read-only; upper nibble is a fixed family code.
// - Startup loads user defaults; corrupted block loads factory defaults and flags it.
// - Watchdog zero is inert; nonzero counts down once per second.
// - Step from one to zero reboots, restores user defaults, leaves watchdog zero.
// - Each transaction to the expander reloads the countdown with last written value.
// - Reboot, writing zero or command 07h clears and disables the watchdog.
// - Command register accepts codes 01h through 07h.
// - Command 01h saves the active configuration as power-up defaults.
// - Command 02h saves factory defaults without touching active settings.
// - Command 03h takes 146 bytes plus XOR CRC; bad or short block is refused.
// - Command 05h takes 146 bytes plus CRC and applies them only when valid.
// - Command 04h returns stored defaults, 146 bytes and a CRC byte.
// - Command 06h returns active configuration, 146 bytes and a CRC byte.
// - Command 07h reloads everything from stored defaults like a power-on.
// - Block bytes 00h-27h: output, mask, PWM select, inversion, direction per port.
// - Bytes 28h-5Fh: seven drive-mode bytes per port, ports 0 to 7.
// - From 60h three bytes per PWM, then divider 90h, enable 91h, CRC 92h.
module expander_config_command_control
	import expander_ctl_pkg::*;
#(
	parameter int TICK_CYCLES = expander_ctl_pkg::SECOND_CYCLES,
	parameter logic [3:0] FAMILY_CODE = 4'hA
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte interface from the I2C slave front end
	input wire logic txn_start,
	input wire logic txn_stop,
	input wire logic wr_valid,
	input wire logic wr_first,
	input wire logic [7:0] wr_data,
	output logic wr_nak,
	input wire logic rd_req,
	output logic [7:0] rd_data,
	// Feature controls
	output logic eeprom_readonly_enable,
	output logic eeprom_operation_enable,
	output logic write_protect_pin_select,
	output logic defaults_source_flag,
	// Active configuration read port for port and PWM logic
	input wire logic [7:0] cfg_addr,
	output logic [7:0] cfg_data,
	output logic cfg_changed,
	output logic busy,
	// Power-up default store
	output logic [7:0] nv_addr,
	output logic nv_we,
	output logic [7:0] nv_wdata,
	input wire logic [7:0] nv_rdata
);
	import expander_ctl_pkg::*;

	// ********************************
	// Storage and state
	// ********************************
	// The FAMILY_CODE default is arbitrary.
	logic [7:0] cfg_mem [0:BLK_LEN-1];
	logic [7:0] stg_mem [0:BLK_LEN];
	eng_e eng_r;
	stream_e stream_r;
	src_e src_r;
	then_e then_r;
	logic [7:0] eng_idx_r;
	logic [7:0] eng_xor_r;
	logic [7:0] blk_idx_r;
	logic [7:0] blk_xor_r;
	logic [7:0] ptr_r;
	logic [7:0] enable_r;
	logic [1:0] key_cnt_r;
	logic key_live_r;
	logic factory_r;
	logic [7:0] wd_reload_r;
	logic [7:0] wd_count_r;
	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
	logic tick;
	logic [7:0] rd_data_r;
	logic [7:0] cfg_data_r;
	logic cfg_changed_r;

	// ********************************
	// Decode
	// ********************************
	logic wr_byte, in_stream_wr, reg_wr, cmd_wr, wd_wr, ena_hit, key_hold;
	logic blk_last, crc_ok, wd_expire, req_load, eng_done;

	function automatic logic [7:0] key_byte(input logic [1:0] i);
		case (i)
			2'h0: key_byte = KEY_BYTE0;
			2'h1: key_byte = KEY_BYTE1;
			default: key_byte = KEY_BYTE2;
		endcase
	endfunction

	function automatic logic [7:0] fact_byte(input logic [7:0] a);
		fact_byte = 8'h00;
		if (a < OFS_IMASK) begin
			fact_byte = FACT_OUT;
		end else if (a < OFS_PWMSEL) begin
			fact_byte = FACT_IMASK;
		end else if (a >= OFS_DRIVE && a < OFS_PWM && ((a - OFS_DRIVE) % DRIVE_PER_PORT) == 8'h00) begin
			fact_byte = FACT_PULLUP;
		end else if (a >= OFS_PWM && a < OFS_DIVIDER && ((a - OFS_PWM) % PWM_PER_CH) == PWM_PERIOD_SLOT) begin
			fact_byte = FACT_PERIOD;
		end else if (a == OFS_DIVIDER) begin
			fact_byte = FACT_DIVIDER;
		end
	endfunction

	// The enable register lives in a flop so it can reset; the block image maps it at its slot.
	function automatic logic [7:0] cfg_byte(input logic [7:0] a);
		if (a == OFS_ENABLE) begin
			cfg_byte = enable_r;
		end else if (a < BLK_LEN) begin
			cfg_byte = cfg_mem[a];
		end else begin
			cfg_byte = 8'h00;
		end
	endfunction

	assign busy = (eng_r != ENG_IDLE);
	assign wr_byte = wr_valid && !wr_first;
	assign in_stream_wr = (stream_r == STR_WR_NV) || (stream_r == STR_WR_CFG);
	assign reg_wr = wr_byte && !in_stream_wr && !busy;
	assign cmd_wr = reg_wr && (ptr_r == REG_COMMAND);
	assign wd_wr = reg_wr && (ptr_r == REG_WATCHDOG);
	assign ena_hit = reg_wr && (ptr_r == REG_FEATURE_ENABLE);
	assign key_hold = ena_hit && key_live_r && (key_cnt_r != KEY_LEN) && (wr_data == key_byte(key_cnt_r));
	assign blk_last = wr_byte && in_stream_wr && (blk_idx_r == BLK_LEN);
	assign crc_ok = blk_last && (wr_data == blk_xor_r) && !busy;
	assign wd_expire = tick && (wd_count_r == 8'h01);
	assign req_load = wd_expire || (cmd_wr && wr_data == CMD_RECONFIG);
	assign eng_done = (eng_r == ENG_APPLY || eng_r == ENG_FACT_CFG) && (eng_idx_r == BLK_LEN - 8'h01);

	// refuse bad or excess block bytes
	assign wr_nak = (wr_byte && busy) || (blk_last && wr_data != blk_xor_r)
		|| (wr_byte && in_stream_wr && blk_idx_r > BLK_LEN);

	// ********************************
	// Register pointer and unlock key
	// ********************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_r <= 8'h00;
		end else if (wr_valid && wr_first) begin
			ptr_r <= wr_data;
		end else if ((reg_wr && !key_hold) || (rd_req && stream_r != STR_RD)) begin
			ptr_r <= ptr_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_cnt_r <= 2'h0;
			key_live_r <= 1'b0;
		// key only counts when 2Dh was addressed directly
		end else if (wr_valid && wr_first) begin
			key_cnt_r <= 2'h0;
			key_live_r <= (wr_data == REG_FEATURE_ENABLE);
		end else if (key_hold) begin
			key_cnt_r <= key_cnt_r + 2'h1;
		end else if (reg_wr) begin
			key_live_r <= 1'b0;
		end
	end

	// ********************************
	// Feature enable register
	// ********************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			enable_r <= ENA_RESET;
		end else if (ena_hit && key_live_r && key_cnt_r == KEY_LEN) begin
			enable_r <= wr_data & ENA_MASK;
		end else if (eng_r == ENG_APPLY && eng_idx_r == OFS_ENABLE) begin
			enable_r <= stg_mem[eng_idx_r] & ENA_MASK;
		end else if (eng_r == ENG_FACT_CFG && eng_idx_r == OFS_ENABLE) begin
			enable_r <= fact_byte(eng_idx_r) & ENA_MASK;
		end
	end

	assign eeprom_readonly_enable = enable_r[ENA_RO_BIT];
	assign eeprom_operation_enable = enable_r[ENA_EE_OP_BIT];
	assign write_protect_pin_select = enable_r[ENA_WP_SEL_BIT];
	assign defaults_source_flag = factory_r;

	// ********************************
	// Watchdog
	// ********************************
	always_ff @(posedge clk) begin
		if (!rst_n || wd_wr) begin
			tick_cnt_r <= '0;
		end else if (tick_cnt_r == $bits(tick_cnt_r)'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign tick = (tick_cnt_r == $bits(tick_cnt_r)'(TICK_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_reload_r <= WD_RESET;
			wd_count_r <= WD_RESET;
		end else if (req_load) begin
			wd_reload_r <= WD_RESET;
			wd_count_r <= WD_RESET;
		end else if (wd_wr) begin
			wd_reload_r <= wr_data;
			wd_count_r <= wr_data;
		end else if (txn_start) begin
			wd_count_r <= wd_reload_r;
		end else if (tick && wd_count_r != WD_RESET) begin
			wd_count_r <= wd_count_r - 8'h01;
		end
	end

	// ********************************
	// Block streaming
	// ********************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stream_r <= STR_NONE;
		end else if (cmd_wr && wr_data == CMD_WRITE_DFLT) begin
			stream_r <= STR_WR_NV;
		end else if (cmd_wr && wr_data == CMD_WRITE_CFG) begin
			stream_r <= STR_WR_CFG;
		end else if ((eng_r == ENG_NV_READ && then_r == THEN_STREAM && eng_idx_r == BLK_LEN + 8'h01)
			|| (eng_r == ENG_SNAP && eng_idx_r == BLK_LEN - 8'h01)) begin
			stream_r <= STR_RD;
		end else if ((wr_valid && wr_first) || blk_last || (txn_stop && in_stream_wr)) begin
			stream_r <= STR_NONE;
		end else if (rd_req && stream_r == STR_RD && blk_idx_r == BLK_LEN) begin
			stream_r <= STR_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || (cmd_wr && wr_data >= CMD_WRITE_DFLT && wr_data <= CMD_READ_CFG)) begin
			blk_idx_r <= 8'h00;
			blk_xor_r <= 8'h00;
		end else if (wr_byte && in_stream_wr && blk_idx_r < BLK_LEN) begin
			blk_idx_r <= blk_idx_r + 8'h01;
			blk_xor_r <= blk_xor_r ^ wr_data;
		end else if (wr_byte && in_stream_wr) begin
			blk_idx_r <= blk_idx_r + 8'h01;
		end else if (rd_req && stream_r == STR_RD && blk_idx_r < BLK_LEN) begin
			blk_idx_r <= blk_idx_r + 8'h01;
			blk_xor_r <= blk_xor_r ^ stg_mem[blk_idx_r];
		end
	end

	// ********************************
	// Read data
	// ********************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_r <= 8'h00;
		end else if (rd_req) begin
			if (stream_r == STR_RD) begin
				rd_data_r <= (blk_idx_r < BLK_LEN) ? stg_mem[blk_idx_r] : blk_xor_r;
			end else begin
				case (ptr_r)
					REG_FEATURE_ENABLE: rd_data_r <= enable_r;
					REG_FAMILY_STATUS: rd_data_r <= {FAMILY_CODE, factory_r ? STATUS_FACTORY : STATUS_USER};
					REG_WATCHDOG: rd_data_r <= wd_count_r;
					default: rd_data_r <= 8'h00;
				endcase
			end
		end
	end
	assign rd_data = rd_data_r;

	// ********************************
	// Staging and active memories
	// ********************************
	always_ff @(posedge clk) begin
		if (wr_byte && in_stream_wr && blk_idx_r < BLK_LEN) begin
			stg_mem[blk_idx_r] <= wr_data;
		end else if (eng_r == ENG_NV_READ && eng_idx_r != 8'h00) begin
			stg_mem[eng_idx_r - 8'h01] <= nv_rdata;
		end else if (eng_r == ENG_SNAP) begin
			stg_mem[eng_idx_r] <= cfg_byte(eng_idx_r);
		end
	end

	always_ff @(posedge clk) begin
		// apply only after a good check
		if (eng_r == ENG_APPLY) begin
			cfg_mem[eng_idx_r] <= stg_mem[eng_idx_r];
		end else if (eng_r == ENG_FACT_CFG) begin
			cfg_mem[eng_idx_r] <= fact_byte(eng_idx_r);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_data_r <= 8'h00;
			cfg_changed_r <= 1'b0;
		end else begin
			cfg_data_r <= cfg_byte(cfg_addr);
			cfg_changed_r <= eng_done;
		end
	end
	assign cfg_data = cfg_data_r;
	assign cfg_changed = cfg_changed_r;

	// ********************************
	// Block engine
	// ********************************
	// A reboot request arriving while the engine runs is dropped; the watchdog is still cleared.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eng_r <= ENG_NV_READ;
			then_r <= THEN_BOOT;
			src_r <= SRC_CFG;
			eng_idx_r <= 8'h00;
			eng_xor_r <= 8'h00;
			factory_r <= 1'b0;
		end else begin
			case (eng_r)
				ENG_IDLE: begin
					eng_idx_r <= 8'h00;
					eng_xor_r <= 8'h00;
					if (req_load) begin
						eng_r <= ENG_NV_READ;
						then_r <= THEN_BOOT;
					end else if (cmd_wr && wr_data == CMD_STORE_CFG) begin
						eng_r <= ENG_NV_WRITE;
						src_r <= SRC_CFG;
					end else if (cmd_wr && wr_data == CMD_FACTORY) begin
						eng_r <= ENG_NV_WRITE;
						src_r <= SRC_FACT;
					end else if (cmd_wr && wr_data == CMD_READ_DFLT) begin
						eng_r <= ENG_NV_READ;
						then_r <= THEN_STREAM;
					end else if (cmd_wr && wr_data == CMD_READ_CFG) begin
						eng_r <= ENG_SNAP;
					end else if (crc_ok && stream_r == STR_WR_NV) begin
						eng_r <= ENG_NV_WRITE;
						src_r <= SRC_STG;
					end else if (crc_ok) begin
						eng_r <= ENG_APPLY;
					end
				end
				ENG_NV_READ: begin
					if (eng_idx_r != 8'h00 && eng_idx_r <= BLK_LEN) begin
						eng_xor_r <= eng_xor_r ^ nv_rdata;
					end
					if (eng_idx_r == BLK_LEN + 8'h01) begin
						eng_idx_r <= 8'h00;
						eng_r <= (then_r == THEN_BOOT) ? ENG_CHECK : ENG_IDLE;
					end else begin
						eng_idx_r <= eng_idx_r + 8'h01;
					end
				end
				ENG_CHECK: begin
					// corrupted store falls back to factory image
					factory_r <= (stg_mem[BLK_LEN] != eng_xor_r);
					eng_r <= (stg_mem[BLK_LEN] == eng_xor_r) ? ENG_APPLY : ENG_FACT_CFG;
				end
				ENG_APPLY, ENG_FACT_CFG, ENG_SNAP: begin
					if (eng_idx_r == BLK_LEN - 8'h01) begin
						eng_r <= ENG_IDLE;
					end
					eng_idx_r <= eng_idx_r + 8'h01;
				end
				ENG_NV_WRITE: begin
					eng_xor_r <= eng_xor_r ^ nv_wdata;
					if (eng_idx_r == BLK_LEN) begin
						eng_r <= ENG_IDLE;
					end
					eng_idx_r <= eng_idx_r + 8'h01;
				end
				default: eng_r <= ENG_IDLE;
			endcase
		end
	end

	// CRC written in the last slot
	always_comb begin
		nv_addr = eng_idx_r;
		nv_we = (eng_r == ENG_NV_WRITE);
		nv_wdata = eng_xor_r;
		if (eng_idx_r < BLK_LEN) begin
			case (src_r)
				SRC_CFG: nv_wdata = cfg_byte(eng_idx_r);
				SRC_FACT: nv_wdata = fact_byte(eng_idx_r);
				default: nv_wdata = stg_mem[eng_idx_r];
			endcase
		end
	end

endmodule // expander_config_command_control

// ==== tb/expander_ctl_chk.sv ====
// Concurrent checks on the ports of the expander control block.
// Assumes one clock and a synchronous active-low reset.
module expander_ctl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte interface
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic wr_nak,
	input wire logic rd_req,
	input wire logic [7:0] rd_data,
	// Controls and status
	input wire logic eeprom_readonly_enable,
	input wire logic eeprom_operation_enable,
	input wire logic write_protect_pin_select,
	input wire logic defaults_source_flag,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_data,
	input wire logic cfg_changed,
	input wire logic busy,
	input wire logic [7:0] nv_addr,
	input wire logic nv_we
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] ena;
	assign ena = {eeprom_readonly_enable, eeprom_operation_enable, write_protect_pin_select};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_clears_enables: assert property (disable iff (1'b0) !rst_n |=> ena == 3'h0)
		else $error("enable bits not cleared by reset");
	a_enable_from_write: assert property ($changed(ena) && !$past(busy) |-> $past(wr_valid) && ena == $past(wr_data[2:0]))
		else $error("enable bits changed without a write");
	a_nak_on_write: assert property (wr_nak |-> wr_valid)
		else $error("refusal outside a written byte");
	a_flag_on_load: assert property ($changed(defaults_source_flag) |-> $past(busy))
		else $error("defaults flag changed outside a load");
	a_store_when_busy: assert property (nv_we |-> busy)
		else $error("store written while idle");
	a_store_in_block: assert property (nv_we |-> nv_addr <= 8'h92)
		else $error("store write beyond the block");
	a_apply_after_busy: assert property (cfg_changed |-> $past(busy))
		else $error("configuration change without engine run");
	a_active_cfg_quiet: assert property (!busy && !$past(busy) && $stable(cfg_addr) && cfg_addr != 8'h91 |=> $stable(cfg_data))
		else $error("active configuration changed while idle");
	a_read_data_held: assert property ($changed(rd_data) |-> $past(rd_req))
		else $error("read data changed without a read");
endmodule // expander_ctl_chk

bind expander_config_command_control expander_ctl_chk i_chk (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
	.wr_data(wr_data), .wr_nak(wr_nak), .rd_req(rd_req), .rd_data(rd_data),
	.eeprom_readonly_enable(eeprom_readonly_enable), .eeprom_operation_enable(eeprom_operation_enable),
	.write_protect_pin_select(write_protect_pin_select), .defaults_source_flag(defaults_source_flag),
	.cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_changed(cfg_changed), .busy(busy), .nv_addr(nv_addr),
	.nv_we(nv_we));

// ==== tb/nv_store_model.sv ====
// Power-up default store: 147 bytes, read data one cycle after the address.
// Assumes the block drives address, strobe and data from its engine.
module nv_store_model (
	// Clock
	input wire logic clk,
	// Store port
	input wire logic [7:0] nv_addr,
	input wire logic nv_we,
	input wire logic [7:0] nv_wdata,
	output logic [7:0] nv_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:146];
	// Starts with a bad check byte, so the first load must fall back to factory.
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[146] = 8'h5A;
		nv_rdata = 8'h00;
	end
	always @(posedge clk) begin
		if (nv_we && nv_addr <= 8'h92) mem[nv_addr] <= nv_wdata;
	end
	always @(posedge clk) begin
		if (nv_addr <= 8'h92) nv_rdata <= mem[nv_addr];
		else nv_rdata <= ~nv_rdata;
	end
endmodule // nv_store_model

// ==== tb/expander_config_command_control_tb.sv ====
// Testbench of the expander control block: byte-level read and write sequences.
// Assumes the store model and the bound checker are compiled alongside.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module expander_config_command_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import expander_ctl_pkg::*;
	// Short tick keeps watchdog runs brief.
	localparam int TICK = 64;
	// Family code value is arbitrary.
	localparam logic [3:0] FAM = 4'hA;
	logic clk = 0, rst_n = 0, txn_start = 0, txn_stop = 0, wr_valid = 0, wr_first = 0, rd_req = 0, nak;
	logic [7:0] wr_data = 8'h00, cfg_addr = 8'h00, nv_rdata, rd_data, cfg_data, nv_addr, nv_wdata, d;
	logic wr_nak, ro, op, sel, flag, cfg_changed, busy, nv_we;
	int failures = 0, n_tests = 0;

	initial forever #2 clk = ~clk;

	expander_config_command_control #(.TICK_CYCLES(TICK), .FAMILY_CODE(FAM)) i_dut (.clk(clk), .rst_n(rst_n),
		.txn_start(txn_start), .txn_stop(txn_stop), .wr_valid(wr_valid), .wr_first(wr_first), .wr_data(wr_data),
		.wr_nak(wr_nak), .rd_req(rd_req), .rd_data(rd_data), .eeprom_readonly_enable(ro),
		.eeprom_operation_enable(op), .write_protect_pin_select(sel), .defaults_source_flag(flag),
		.cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_changed(cfg_changed), .busy(busy), .nv_addr(nv_addr),
		.nv_we(nv_we), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));
	nv_store_model i_nv (.clk(clk), .nv_addr(nv_addr), .nv_we(nv_we), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));

	// ****
	// Access tasks
	// ****
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task put(input logic f, input logic [7:0] v);
		@(posedge clk);
		#1;
		wr_valid = 1'b1;
		wr_first = f;
		wr_data = v;
		txn_start = f;
		#2;
		nak = wr_nak;
		@(posedge clk);
		#1;
		wr_valid = 1'b0;
		txn_start = 1'b0;
	endtask
	task pull(output logic [7:0] v);
		@(posedge clk);
		#1;
		rd_req = 1'b1;
		@(posedge clk);
		#1;
		rd_req = 1'b0;
		v = rd_data;
	endtask
	task rd(input logic [7:0] p, output logic [7:0] v);
		put(1'b1, p);
		pull(v);
	endtask
	// A limit that runs out ends the run as a mismatch.
	task wait_busy(input logic b, input int lim);
		for (int i = 0; i < lim && busy !== b; i++) begin
			@(posedge clk);
			#1;
		end
		if (busy !== b) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, busy, b);
			final_report();
		end
	endtask
	task cmd(input logic [7:0] c);
		wait_busy(1'b0, 400);
		put(1'b1, REG_COMMAND);
		put(1'b0, c);
	endtask
	function automatic logic [7:0] ex(input logic k, input logic [7:0] s, input int i);
		if (!k) return 8'(i) ^ s;
		if (i < 16 || i == 8'h90 || (i >= 8'h28 && i < 8'h60 && (i - 8'h28) % 7 == 0)) return 8'hFF;
		if (i >= 8'h60 && i < 8'h90 && (i - 8'h60) % 3 == 1) return 8'hFF;
		return 8'h00;
	endfunction
	task blk(input logic [7:0] c, input logic [7:0] s, input logic bad);
		logic [7:0] x;
		x = 8'h00;
		cmd(c);
		for (int i = 0; i < 146; i++) begin
			put(1'b0, ex(1'b0, s, i));
			x ^= ex(1'b0, s, i);
		end
		put(1'b0, x ^ {7'h00, bad});
		`CHK(nak, bad)
		wait_busy(1'b0, 400);
	endtask
	// The active enable byte keeps only its three defined bits, so m masks slot 91h.
	task rstream(input logic k, input logic [7:0] s, input logic m);
		logic [7:0] x;
		logic [7:0] e;
		x = 8'h00;
		wait_busy(1'b0, 400);
		for (int i = 0; i < 146; i++) begin
			e = ex(k, s, i);
			if (m && i == 8'h91) e = e & ENA_MASK;
			pull(d);
			`CHK(d, e)
			x ^= e;
		end
		pull(d);
		`CHK(d, x)
	endtask
	task chk_cfg(input logic [7:0] s);
		logic [7:0] e;
		e = ex(1'b0, s, 8'h91);
		for (int i = 0; i < 145; i += 5) begin
			@(posedge clk);
			#1;
			cfg_addr = 8'(i);
			@(posedge clk);
			#1;
			`CHK(cfg_data, ex(1'b0, s, i))
		end
		`CHK({ro, op, sel}, e[2:0])
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		wait_busy(1'b0, 400);
		`CHK(flag, 1'b1)
		rd(REG_FAMILY_STATUS, d);
		`CHK(d, {FAM, 4'hF})
		rd(REG_FEATURE_ENABLE, d);
		`CHK(d, 8'h00)
		repeat (300) @(posedge clk);
		#1;
		`CHK(busy, 1'b0)
		$display("end reset");
		put(1'b1, REG_FEATURE_ENABLE);
		put(1'b0, 8'h07);
		rd(REG_FEATURE_ENABLE, d);
		`CHK(d, 8'h00)
		put(1'b1, REG_FEATURE_ENABLE);
		put(1'b0, KEY_BYTE0);
		put(1'b0, KEY_BYTE1);
		put(1'b0, KEY_BYTE2);
		put(1'b0, 8'h07);
		`CHK({ro, op, sel}, 3'h7)
		rd(REG_FEATURE_ENABLE, d);
		`CHK(d, 8'h07)
		put(1'b1, 8'h2C);
		put(1'b0, 8'h11);
		put(1'b0, 8'h00);
		put(1'b0, 8'h00);
		put(1'b0, 8'h05);
		rd(REG_FEATURE_ENABLE, d);
		`CHK(d, 8'h07)
		rd(REG_WATCHDOG, d);
		`CHK(d == 8'h05 || d == 8'h04, 1'b1)
		rd(REG_FAMILY_STATUS, d);
		`CHK(d, {FAM, 4'hF})
		$display("end enable register");
		repeat (10) begin
			repeat (40) @(posedge clk);
			put(1'b1, REG_WATCHDOG);
			`CHK(busy, 1'b0)
		end
		wait_busy(1'b1, 400);
		wait_busy(1'b0, 400);
		`CHK({ro, op, sel}, 3'h0)
		rd(REG_WATCHDOG, d);
		`CHK(d, 8'h00)
		$display("end watchdog");
		blk(CMD_WRITE_CFG, 8'h5A, 1'b0);
		chk_cfg(8'h5A);
		blk(CMD_WRITE_CFG, 8'h33, 1'b1);
		chk_cfg(8'h5A);
		cmd(CMD_READ_CFG);
		rstream(1'b0, 8'h5A, 1'b1);
		cmd(CMD_WRITE_CFG);
		d = 8'h00;
		for (int i = 0; i < 146; i++) begin
			put(1'b0, ex(1'b0, 8'h77, i));
			d ^= ex(1'b0, 8'h77, i);
		end
		@(posedge clk);
		#1;
		txn_stop = 1'b1;
		@(posedge clk);
		#1;
		txn_stop = 1'b0;
		put(1'b0, d);
		`CHK(nak, 1'b0)
		repeat (4) @(posedge clk);
		#1;
		`CHK(busy, 1'b0)
		chk_cfg(8'h5A);
		blk(CMD_WRITE_DFLT, 8'h21, 1'b0);
		blk(CMD_WRITE_DFLT, 8'h44, 1'b1);
		chk_cfg(8'h5A);
		cmd(CMD_READ_DFLT);
		rstream(1'b0, 8'h21, 1'b0);
		cmd(CMD_STORE_CFG);
		cmd(CMD_READ_DFLT);
		rstream(1'b0, 8'h5A, 1'b1);
		$display("end block commands");
		put(1'b1, REG_WATCHDOG);
		put(1'b0, 8'h09);
		cmd(CMD_RECONFIG);
		wait_busy(1'b0, 400);
		`CHK(flag, 1'b0)
		rd(REG_FAMILY_STATUS, d);
		`CHK(d, {FAM, 4'h0})
		rd(REG_WATCHDOG, d);
		`CHK(d, 8'h00)
		chk_cfg(8'h5A);
		cmd(CMD_FACTORY);
		cmd(CMD_READ_DFLT);
		rstream(1'b1, 8'h00, 1'b0);
		chk_cfg(8'h5A);
		$display("end reconfigure and factory");
		final_report();
	end
endmodule // expander_config_command_control_tb
